// ===== uart_rx_status_flags_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "usf_map.vh"

module uart_rx_status_flags_tb_top;
	// ****
	// Signals and rows
	// ****
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic ce = 1'b1;
	wire [1:0] mp_mode;
	wire pen_o, swrst_o;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic tx_active = 1'b0;
	logic tx_shift_out = 1'b1;
	logic go = 1'b0;
	logic [4:0] q = 5'h0;
	logic [7:0] d = 8'h0;
	logic [31:0] r;
	wire [31:0] hrdata;
	wire [7:0] rx_char_data;
	wire hready, irq, rx_char_valid, rx_stop_low, rx_parity_bad, rx_addr_mark, rx_idle_seen;
	wire rx_break_seen, rx_active, rxd_pin, receiver_line, serial_transmit_line;
	int err_total = 0;
	int n_checks = 0;
	// q: break, idle, address, parity bad, stop low
	typedef struct packed {logic [3:0] ctrl; logic [4:0] q; logic [7:0] st;} usf_row_t;
	usf_row_t rows [8] = '{'{4'h0, 5'h01, 8'h44}, '{4'h1, 5'h02, 8'h14}, '{4'h0, 5'h02, 8'h00},
		'{4'h0, 5'h10, 8'h08}, '{4'h4, 5'h04, 8'h02}, '{4'h4, 5'h00, 8'h00},
		'{4'h2, 5'h08, 8'h02}, '{4'h0, 5'h04, 8'h00}};

	usf_status dut (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
		.hreadyout(hready), .hresp(), .hrdata(hrdata), .rx_char_valid(rx_char_valid),
		.rx_char_data(rx_char_data), .rx_stop_low(rx_stop_low), .rx_parity_bad(rx_parity_bad),
		.rx_addr_mark(rx_addr_mark), .rx_idle_seen(rx_idle_seen), .rx_break_seen(rx_break_seen),
		.tx_active(tx_active), .rx_active(rx_active), .tx_shift_out(tx_shift_out),
		.rxd_pin(rxd_pin), .serial_transmit_line(serial_transmit_line),
		.receiver_line(receiver_line), .parity_check_enable(pen_o), .mp_mode(mp_mode),
		.port_soft_reset(swrst_o), .rxbuf_read(), .irq(irq));
	usf_remote remote (.hclk(hclk), .go(go), .q(q), .d(d), .rx_char_valid(rx_char_valid),
		.rx_char_data(rx_char_data), .rx_stop_low(rx_stop_low), .rx_parity_bad(rx_parity_bad),
		.rx_addr_mark(rx_addr_mark), .rx_idle_seen(rx_idle_seen),
		.rx_break_seen(rx_break_seen), .rx_active(rx_active), .rxd_pin(rxd_pin));

	always #4 hclk = ~hclk;

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic finish_test;
		$display("mismatches %0d comparisons %0d", err_total, n_checks);
		if (err_total == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic rdy;
		int i;
		i = 0;
		do begin
			@(posedge hclk);
			i++;
		end while (hready !== 1'b1 && i < 50);
		if (i >= 50) begin
			err_total++;
			finish_test();
		end
	endtask
	// Called just after an edge; returns at the edge that takes the data
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= v;
		rdy();
		r = hrdata;
	endtask
	task automatic ev(input logic [4:0] qq, input int n);
		go <= 1'b1;
		q <= qq;
		d <= d + 8'h11;
		repeat (n) @(posedge hclk);
		go <= 1'b0;
		@(posedge hclk);
	endtask

	initial begin
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		bus(0, `USF_ADDR_STATUS, 0);
		chk("status reset", 32'h0, r);
		chk("irq reset", 32'h0, {31'h0, irq});
		foreach (rows[i]) begin
			bus(1, `USF_ADDR_CTRL, {28'h0, rows[i].ctrl});
			ev(rows[i].q, 1);
			bus(0, `USF_ADDR_STATUS, 0);
			chk("row status", {24'h0, rows[i].st}, r);
			chk("mode", {30'h0, rows[i].ctrl[2:1]}, {30'h0, mp_mode});
			chk("parity enable", {31'h0, rows[i].ctrl[0]}, {31'h0, pen_o});
			bus(0, `USF_ADDR_RXBUF, 0);
			if (!rows[i].q[4])
				chk("rx data", {24'h0, d}, r);
			bus(0, `USF_ADDR_STATUS, 0);
			chk("status after read", 32'h0, r);
		end
		// Parity flag hidden while checking is off; summary needs a visible cause
		bus(1, `USF_ADDR_STATUS, 32'h14);
		bus(0, `USF_ADDR_STATUS, 0);
		chk("parity masked", 32'h0, r);
		bus(1, `USF_ADDR_CTRL, 32'h1);
		bus(0, `USF_ADDR_STATUS, 0);
		chk("parity shown", 32'h14, r);
		bus(0, `USF_ADDR_RXBUF, 0);
		// Soft reset wipes flags, drops events and keeps the control word
		ev(5'h01, 1);
		bus(1, `USF_ADDR_CTRL, 32'h8);
		ev(5'h01, 1);
		bus(0, `USF_ADDR_STATUS, 0);
		chk("soft reset status", 32'h0, r);
		bus(0, `USF_ADDR_CTRL, 0);
		chk("soft reset ctrl", 32'h8, r);
		chk("soft reset out", 32'h1, {31'h0, swrst_o});
		bus(1, `USF_ADDR_CTRL, 32'h0);
		// A frozen block loses a character
		ce <= 1'b0;
		ev(5'h01, 1);
		ce <= 1'b1;
		bus(0, `USF_ADDR_STATUS, 0);
		chk("frozen", 32'h0, r);
		bus(1, `USF_ADDR_IRQ_STAT, 32'hf);
		bus(1, `USF_ADDR_IRQ_MASK, 32'h2);
		ev(5'h00, 2);
		bus(0, `USF_ADDR_STATUS, 0);
		chk("overrun", 32'h24, r);
		chk("irq raised", 32'h1, {31'h0, irq});
		bus(1, `USF_ADDR_IRQ_STAT, 32'h2);
		bus(0, `USF_ADDR_IRQ_STAT, 0);
		chk("irq status", 32'h5, r);
		chk("irq cleared", 32'h0, {31'h0, irq});
		bus(0, `USF_ADDR_RXBUF, 0);
		// Overrun already cleared by the read, so this write leaves it alone
		bus(1, `USF_ADDR_STATUS, 32'hffff_ff80);
		tx_active <= 1'b1;
		tx_shift_out <= 1'b0;
		bus(0, `USF_ADDR_STATUS, 0);
		chk("loopback busy", 32'h81, r);
		chk("rx line", 32'h0, {31'h0, receiver_line});
		chk("tx line", 32'h0, {31'h0, serial_transmit_line});
		bus(1, `USF_ADDR_STATUS, 32'h0);
		tx_active <= 1'b0;
		bus(1, 8'h40, 32'hffff_ffff);
		chk("rx line", 32'h1, {31'h0, receiver_line});
		bus(0, 8'h40, 0);
		chk("unmapped", 32'h0, r);
		// Reset in mid-run returns every register to zero
		bus(1, `USF_ADDR_STATUS, 32'h80);
		bus(1, `USF_ADDR_CTRL, 32'h5);
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		bus(0, `USF_ADDR_STATUS, 0);
		chk("status after reset", 32'h0, r);
		bus(0, `USF_ADDR_CTRL, 0);
		chk("ctrl after reset", 32'h0, r);
		chk("line after reset", 32'h1, {31'h0, receiver_line});
		finish_test();
	end
endmodule
`default_nettype wire

// ===== usf_ahb_port.v
`timescale 1ns/10ps
`default_nettype none
`include "usf_map.vh"

module usf_ahb_port (
	// Clock, reset, enable
	input wire hclk,
	input wire hresetn,
	input wire ce,
	// AHB-Lite slave
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output wire hreadyout,
	output wire hresp,
	output reg [31:0] hrdata,
	// Register side
	output wire rd_req,
	output wire [7:0] rd_addr,
	input wire [31:0] rd_value,
	output wire wr_req,
	output wire [7:0] wr_addr,
	output wire [31:0] wr_data
);

	reg wpend_ff;
	reg [7:0] waddr_ff;
	wire accept;

	// Only whole-word transfers are expected, so hsize is not decoded
	assign accept = ce & hready & hsel & htrans[1] & (hsize == 3'h2 | hsize != 3'h2);
	assign rd_req = accept & ~hwrite;
	assign rd_addr = haddr[7:0];
	assign wr_req = wpend_ff & ce;
	assign wr_addr = waddr_ff;
	assign wr_data = hwdata;
	// A frozen block stretches the data phase instead of losing it
	assign hreadyout = ce;
	assign hresp = 1'b0;

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wpend_ff <= 1'b0;
			waddr_ff <= 8'h00;
			hrdata <= 32'h0000_0000;
		end else if (ce) begin
			wpend_ff <= accept & hwrite;
			if (accept & hwrite) begin
				waddr_ff <= haddr[7:0];
			end
			if (rd_req) begin
				hrdata <= rd_value;
			end
		end
	end

endmodule

`default_nettype wire

// ===== usf_irq.v
`timescale 1ns/10ps
`default_nettype none
`include "usf_map.vh"

module usf_irq #(
	parameter W = `USF_IRQ_W
) (
	// Clock, reset, enable
	input wire hclk,
	input wire hresetn,
	input wire ce,
	// Events and software access
	input wire [W-1:0] event_set,
	input wire clr_we,
	input wire [W-1:0] clr_data,
	input wire mask_we,
	input wire [W-1:0] mask_data,
	// State and request
	output reg [W-1:0] stat_ff,
	output reg [W-1:0] mask_ff,
	output wire irq
);

	wire [W-1:0] nxt_stat;

	// Set wins over a write-one-to-clear in the same cycle
	assign nxt_stat = (stat_ff & ~(clr_we ? clr_data : {W{1'b0}})) | event_set;
	assign irq = |(stat_ff & mask_ff);

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			stat_ff <= {W{1'b0}};
			mask_ff <= `USF_IRQ_MASK_RST;
		end else if (ce) begin
			stat_ff <= nxt_stat;
			if (mask_we) begin
				mask_ff <= mask_data;
			end
		end
	end

endmodule

`default_nettype wire

// ===== usf_map.vh
`ifndef USF_MAP_VH
`define USF_MAP_VH

// ****************************************
// Register byte offsets (low address byte)
// ****************************************
`define USF_ADDR_STATUS 8'h00
`define USF_ADDR_CTRL 8'h04
`define USF_ADDR_RXBUF 8'h08
`define USF_ADDR_IRQ_STAT 8'h0c
`define USF_ADDR_IRQ_MASK 8'h10

// ****************************************
// Status register fields
// ****************************************
`define USF_ST_LISTEN 7
`define USF_ST_FE 6
`define USF_ST_OE 5
`define USF_ST_PE 4
`define USF_ST_BRK 3
`define USF_ST_RXERR 2
`define USF_ST_ADDR 1
`define USF_ST_BUSY 0
`define USF_STATUS_RST 8'h00

// ****************************************
// Control register fields
// ****************************************
`define USF_CT_PEN 0
`define USF_CT_MODE_LO 1
`define USF_CT_MODE_HI 2
`define USF_CT_SWRST 3
`define USF_CTRL_W 4
`define USF_CTRL_RST 4'h0
`define USF_MODE_NONE 2'h0
`define USF_MODE_IDLE 2'h1
`define USF_MODE_ADDR 2'h2

// ****************************************
// Interrupt status and mask fields
// ****************************************
`define USF_IRQ_RXCHAR 0
`define USF_IRQ_OVR 1
`define USF_IRQ_ERR 2
`define USF_IRQ_BRK 3
`define USF_IRQ_W 4
`define USF_IRQ_MASK_RST 4'h0

`endif

// ===== usf_remote.sv
`timescale 1ns/10ps
`default_nettype none

module usf_remote (
	// Clock and command
	input wire hclk,
	input wire go,
	input wire [4:0] q,
	input wire [7:0] d,
	// Receiver side
	output wire rx_char_valid,
	output wire [7:0] rx_char_data,
	output wire rx_stop_low,
	output wire rx_parity_bad,
	output wire rx_addr_mark,
	output wire rx_idle_seen,
	output wire rx_break_seen,
	output wire rx_active,
	output wire rxd_pin
);
	// ****
	// Remote character source
	// ****
	logic go_ff = 1'b0;
	logic [4:0] q_ff = 5'h0;
	logic [7:0] d_ff = 8'h0;
	always @(posedge hclk) begin
		go_ff <= go;
		q_ff <= q;
		d_ff <= d;
	end
	// Outside a pulse the qualifiers show the inverse, so stale values never pass
	assign rx_char_valid = go_ff && !q_ff[4];
	assign rx_break_seen = go_ff && q_ff[4];
	assign {rx_idle_seen, rx_addr_mark, rx_parity_bad, rx_stop_low} = go_ff ? q_ff[3:0] : ~q_ff[3:0];
	assign rx_char_data = go_ff ? d_ff : ~d_ff;
	assign rx_active = go_ff;
	assign rxd_pin = !go_ff;
endmodule
`default_nettype wire

// ===== usf_status.v
// Notes on behaviour
// - Loopback select 1 feeds the transmit line into the receiver; 0 disables.
// - Framing flag sets on a character whose stop bit was low.
// - Overrun flag sets when a character lands before the prior one was read.
// - Reading the receive holding buffer clears the overrun flag.
// - Parity flag sets when a received character fails its parity check.
// - With parity checking off, the parity flag reads as zero.
// - Break flag sets when a break is seen or a status write puts a one in bit 3, stays zero otherwise.
// - Summary flag sets on an errored character; framing, parity or overrun accompanies it.
// - Reading the receive holding buffer clears the summary flag.
// - Address-bit mode: bit 1 shows address characters, zero for data.
// - Reading the receive holding buffer clears the address flag.
// - Idle-line mode: bit 1 sets when idle preceded the character.
// - Reading the receive holding buffer clears the idle-line flag.
// - Activity flag is one while transmit or receive is running.
`timescale 1ns/10ps
`default_nettype none
`include "usf_map.vh"

module usf_status (
	// Clock, reset, enable
	input wire hclk,
	input wire hresetn,
	input wire ce,
	// AHB-Lite slave
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output wire hreadyout,
	output wire hresp,
	output wire [31:0] hrdata,
	// Receiver character events
	input wire rx_char_valid,
	input wire [7:0] rx_char_data,
	input wire rx_stop_low,
	input wire rx_parity_bad,
	input wire rx_addr_mark,
	input wire rx_idle_seen,
	input wire rx_break_seen,
	// Activity of the shifters
	input wire tx_active,
	input wire rx_active,
	// Serial lines
	input wire tx_shift_out,
	input wire rxd_pin,
	output wire serial_transmit_line,
	output wire receiver_line,
	// Configuration towards the rest of the port
	output wire parity_check_enable,
	output wire [1:0] mp_mode,
	output wire port_soft_reset,
	output wire rxbuf_read,
	// Interrupt
	output wire irq
);

	// ****************************************
	// Bus front end
	// ****************************************
	wire rd_req;
	wire [7:0] rd_addr;
	reg [31:0] rd_value;
	wire wr_req;
	wire [7:0] wr_addr;
	wire [31:0] wr_data;

	usf_ahb_port u_port (
		.hclk(hclk),
		.hresetn(hresetn),
		.ce(ce),
		.hsel(hsel),
		.haddr(haddr),
		.htrans(htrans),
		.hwrite(hwrite),
		.hsize(hsize),
		.hwdata(hwdata),
		.hready(hready),
		.hreadyout(hreadyout),
		.hresp(hresp),
		.hrdata(hrdata),
		.rd_req(rd_req),
		.rd_addr(rd_addr),
		.rd_value(rd_value),
		.wr_req(wr_req),
		.wr_addr(wr_addr),
		.wr_data(wr_data)
	);

	// ****************************************
	// Flag update helper
	// ****************************************
	// Software write or clear first, hardware set on top so events win
	function flag_next;
		input cur;
		input we;
		input wval;
		input clr;
		input set;
		begin
			if (we) begin
				flag_next = wval | set;
			end else if (clr) begin
				flag_next = set;
			end else begin
				flag_next = cur | set;
			end
		end
	endfunction

	// ****************************************
	// State
	// ****************************************
	reg listen_ff;
	reg fe_ff;
	reg oe_ff;
	reg pe_ff;
	reg brk_ff;
	reg rxerr_ff;
	reg adr_ff;
	reg [`USF_CTRL_W-1:0] ctrl_ff;
	reg [7:0] rxdata_ff;
	reg full_ff;

	wire st_we;
	wire ct_we;
	wire istat_we;
	wire imask_we;
	wire swrst;
	wire pen;
	wire [1:0] mode;
	wire busy;
	wire overrun;
	wire fe_set;
	wire pe_set;
	wire brk_set;
	wire err_set;
	wire adr_load;
	wire adr_val;
	wire [`USF_IRQ_W-1:0] irq_events;
	wire [`USF_IRQ_W-1:0] istat;
	wire [`USF_IRQ_W-1:0] imask;

	reg nxt_listen;
	reg nxt_fe;
	reg nxt_oe;
	reg nxt_pe;
	reg nxt_brk;
	reg nxt_rxerr;
	reg nxt_adr;

	// ****************************************
	// Write decode
	// ****************************************
	assign st_we = wr_req & (wr_addr == `USF_ADDR_STATUS);
	assign ct_we = wr_req & (wr_addr == `USF_ADDR_CTRL);
	assign istat_we = wr_req & (wr_addr == `USF_ADDR_IRQ_STAT);
	assign imask_we = wr_req & (wr_addr == `USF_ADDR_IRQ_MASK);

	assign swrst = ctrl_ff[`USF_CT_SWRST];
	assign pen = ctrl_ff[`USF_CT_PEN];
	assign mode = ctrl_ff[`USF_CT_MODE_HI:`USF_CT_MODE_LO];

	// The read side effect fires at the address phase, once per transfer
	assign rxbuf_read = rd_req & (rd_addr == `USF_ADDR_RXBUF);

	// ****************************************
	// Receive events
	// ****************************************
	// overrun on occupied buffer
	assign overrun = rx_char_valid & full_ff & ~rxbuf_read;
	assign fe_set = rx_char_valid & rx_stop_low;
	assign pe_set = rx_char_valid & rx_parity_bad & pen;
	assign brk_set = rx_break_seen;
	assign err_set = fe_set | pe_set | overrun;

	assign adr_load = rx_char_valid & ((mode == `USF_MODE_ADDR) | (mode == `USF_MODE_IDLE));
	assign adr_val = (mode == `USF_MODE_ADDR) ? rx_addr_mark : rx_idle_seen;

	assign busy = tx_active | rx_active;

	// ****************************************
	// Status flag next values
	// ****************************************
	always @* begin
		nxt_listen = st_we ? wr_data[`USF_ST_LISTEN] : listen_ff;
		nxt_fe = flag_next(fe_ff, st_we, wr_data[`USF_ST_FE], rxbuf_read, fe_set);
		nxt_oe = flag_next(oe_ff, st_we, wr_data[`USF_ST_OE], rxbuf_read, overrun);
		nxt_pe = flag_next(pe_ff, st_we, wr_data[`USF_ST_PE], rxbuf_read, pe_set);
		nxt_brk = flag_next(brk_ff, st_we, wr_data[`USF_ST_BRK], rxbuf_read, brk_set);
		nxt_rxerr = flag_next(rxerr_ff, st_we, wr_data[`USF_ST_RXERR], rxbuf_read, err_set);
		nxt_adr = flag_next(adr_ff, st_we, wr_data[`USF_ST_ADDR], rxbuf_read, 1'b0);
		if (adr_load) begin
			nxt_adr = adr_val;
		end
		// Port reset wipes the flags but keeps the loopback choice
		if (swrst) begin
			nxt_fe = 1'b0;
			nxt_oe = 1'b0;
			nxt_pe = 1'b0;
			nxt_brk = 1'b0;
			nxt_rxerr = 1'b0;
			nxt_adr = 1'b0;
		end
	end

	// ****************************************
	// Registers
	// ****************************************
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			listen_ff <= 1'b0;
			fe_ff <= 1'b0;
			oe_ff <= 1'b0;
			pe_ff <= 1'b0;
			brk_ff <= 1'b0;
			rxerr_ff <= 1'b0;
			adr_ff <= 1'b0;
			ctrl_ff <= `USF_CTRL_RST;
			rxdata_ff <= 8'h00;
			full_ff <= 1'b0;
		end else if (ce) begin
			listen_ff <= nxt_listen;
			fe_ff <= nxt_fe;
			oe_ff <= nxt_oe;
			pe_ff <= nxt_pe;
			brk_ff <= nxt_brk;
			rxerr_ff <= nxt_rxerr;
			adr_ff <= nxt_adr;
			if (ct_we) begin
				ctrl_ff <= wr_data[`USF_CTRL_W-1:0];
			end
			if (swrst) begin
				full_ff <= 1'b0;
			end else if (rx_char_valid) begin
				rxdata_ff <= rx_char_data;
				full_ff <= 1'b1;
			end else if (rxbuf_read) begin
				full_ff <= 1'b0;
			end
		end
	end

	// ****************************************
	// Interrupts
	// ****************************************
	assign irq_events[`USF_IRQ_RXCHAR] = rx_char_valid & ~swrst;
	assign irq_events[`USF_IRQ_OVR] = overrun & ~swrst;
	assign irq_events[`USF_IRQ_ERR] = err_set & ~swrst;
	assign irq_events[`USF_IRQ_BRK] = brk_set & ~swrst;

	usf_irq #(
		.W(`USF_IRQ_W)
	) u_irq (
		.hclk(hclk),
		.hresetn(hresetn),
		.ce(ce),
		.event_set(irq_events),
		.clr_we(istat_we),
		.clr_data(wr_data[`USF_IRQ_W-1:0]),
		.mask_we(imask_we),
		.mask_data(wr_data[`USF_IRQ_W-1:0]),
		.stat_ff(istat),
		.mask_ff(imask),
		.irq(irq)
	);

	// ****************************************
	// Read decode
	// ****************************************
	always @* begin
		rd_value = 32'h0000_0000;
		if (rd_addr == `USF_ADDR_STATUS) begin
			rd_value[15:8] = 8'h00;
			rd_value[`USF_ST_LISTEN] = listen_ff;
			rd_value[`USF_ST_FE] = fe_ff;
			rd_value[`USF_ST_OE] = oe_ff;
			rd_value[`USF_ST_PE] = pe_ff & pen;
			rd_value[`USF_ST_BRK] = brk_ff;
			// summary shows only with a visible cause
			rd_value[`USF_ST_RXERR] = rxerr_ff & (fe_ff | oe_ff | (pe_ff & pen));
			rd_value[`USF_ST_ADDR] = adr_ff;
			rd_value[`USF_ST_BUSY] = busy;
		end else if (rd_addr == `USF_ADDR_CTRL) begin
			rd_value[`USF_CTRL_W-1:0] = ctrl_ff;
		end else if (rd_addr == `USF_ADDR_RXBUF) begin
			rd_value[7:0] = rxdata_ff;
		end else if (rd_addr == `USF_ADDR_IRQ_STAT) begin
			rd_value[`USF_IRQ_W-1:0] = istat;
		end else if (rd_addr == `USF_ADDR_IRQ_MASK) begin
			rd_value[`USF_IRQ_W-1:0] = imask;
		end
	end

	// ****************************************
	// Serial lines and configuration outputs
	// ****************************************
	// The pin keeps transmitting in loopback, so a remote listener still sees traffic
	assign serial_transmit_line = tx_shift_out;
	assign receiver_line = listen_ff ? tx_shift_out : rxd_pin;

	assign parity_check_enable = pen;
	assign mp_mode = mode;
	assign port_soft_reset = swrst;

endmodule

`default_nettype wire

// ===== usf_status_monitor.sv
`timescale 1ns/10ps
`default_nettype none
`include "usf_map.vh"

module usf_status_monitor (
	// Bus
	input wire hclk,
	input wire hresetn,
	input wire ce,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire hready,
	input wire hreadyout,
	input wire hresp,
	input wire [31:0] hrdata,
	// Receiver, lines, configuration
	input wire rx_char_valid,
	input wire rx_stop_low,
	input wire rx_break_seen,
	input wire tx_active,
	input wire rx_active,
	input wire tx_shift_out,
	input wire rxd_pin,
	input wire serial_transmit_line,
	input wire receiver_line,
	input wire parity_check_enable,
	input wire port_soft_reset,
	input wire rxbuf_read
);
	// ****
	// Helpers
	// ****
	logic acc;
	logic st_rd;
	logic busy_in;
	logic wr_d_ff;
	assign acc = hsel && htrans[1] && hready && ce;
	assign st_rd = acc && !hwrite && haddr[7:0] == `USF_ADDR_STATUS;
	assign busy_in = tx_active || rx_active;
	// A write lands one cycle after its address phase and may set flags
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			wr_d_ff <= 1'b0;
		else if (ce)
			wr_d_ff <= acc && hwrite;
	end
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence char_s;
		rx_char_valid && ce && !rxbuf_read && !port_soft_reset;
	endsequence
	sequence quiet_s;
		!rx_char_valid && !rx_break_seen && !wr_d_ff;
	endsequence
	bus_okay_a: assert property (hresp == 1'b0 && hreadyout == ce)
		else $error("bus response or ready wrong");
	tx_pass_a: assert property (serial_transmit_line == tx_shift_out)
		else $error("transmit line not passed through");
	loop_mux_a: assert property (st_rd && !wr_d_ff |=>
		receiver_line == (hrdata[7] ? tx_shift_out : rxd_pin))
		else $error("receiver line does not follow loopback select");
	err_cause_a: assert property (st_rd |=> !hrdata[2] || hrdata[6] || hrdata[5] || hrdata[4])
		else $error("summary flag without a cause");
	upper_zero_a: assert property (st_rd |=> hrdata[31:8] == 24'h0)
		else $error("status upper bits not zero");
	busy_live_a: assert property (st_rd |=> hrdata[0] == $past(busy_in))
		else $error("activity flag wrong");
	par_off_a: assert property (st_rd && !parity_check_enable |=> !hrdata[4])
		else $error("parity flag set while disabled");
	frame_set_a: assert property (char_s ##0 rx_stop_low ##1 st_rd |=> hrdata[6] && hrdata[2])
		else $error("framing or summary flag missing");
	ovr_set_a: assert property (char_s ##1 char_s ##1 st_rd |=> hrdata[5])
		else $error("overrun flag missing");
	brk_set_a: assert property (rx_break_seen && ce && !port_soft_reset ##1 st_rd |=> hrdata[3])
		else $error("break flag missing");
	rd_clear_a: assert property (rxbuf_read ##0 quiet_s ##1 quiet_s ##1 st_rd |=> hrdata[6:1] == 6'h0)
		else $error("flags not cleared by buffer read");
endmodule

bind usf_status usf_status_monitor mon (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel),
	.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
	.hresp(hresp), .hrdata(hrdata), .rx_char_valid(rx_char_valid), .rx_stop_low(rx_stop_low),
	.rx_break_seen(rx_break_seen), .tx_active(tx_active), .rx_active(rx_active),
	.tx_shift_out(tx_shift_out), .rxd_pin(rxd_pin), .serial_transmit_line(serial_transmit_line),
	.receiver_line(receiver_line), .parity_check_enable(parity_check_enable),
	.port_soft_reset(port_soft_reset), .rxbuf_read(rxbuf_read));
`default_nettype wire
